// >>> src/dcf_read_flags.sv
// Dual-clock buffer core with read control, offset programming and flags
//
// Strobed register access and the address map were chosen for this implementation.
module dcf_read_flags #(
  parameter int DEPTH = dcf_pkg::DEPTH_SMALL
) (
  // System clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  // Device resets, synchronous, active low
  input  wire logic                        full_reset_n,
  input  wire logic                        partial_clear_n,
  // Write side, wrTick marks a write-clock edge
  input  wire logic                        wrTick,
  input  wire logic                        write_en_n,
  input  wire logic [dcf_pkg::DATA_W-1:0]  wrData,
  // Read side, rdTick marks a read-clock edge
  input  wire logic                        rdTick,
  input  wire logic                        read_en_n,
  input  wire logic                        output_drive_n,
  output      logic [dcf_pkg::DATA_W-1:0]  readDataOut,
  output      logic                        readDataOeN,
  // Offset programming pins
  input  wire logic                        offset_access_n,
  input  wire logic                        serial_load_gate_n,
  input  wire logic                        mode_or_serial_in,
  // Parallel offset port
  input  wire logic [dcf_pkg::REG_AW-1:0]  regAddr,
  input  wire logic [dcf_pkg::REG_DW-1:0]  regWrData,
  input  wire logic                        regWr,
  input  wire logic                        regRd,
  output      logic [dcf_pkg::REG_DW-1:0]  regRdData,
  // Flags, active low; fullFlagN and emptyFlagN are active high in fall-through mode
  output      logic                        fullFlagN,
  output      logic                        emptyFlagN,
  output      logic                        almostFullN,
  output      logic                        almostEmptyN
);
  localparam int ADDRW = $clog2(DEPTH);
  localparam int PW    = ADDRW + 1;
  localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);
  localparam logic [dcf_pkg::CNT_W-1:0] DEPTH_C = dcf_pkg::CNT_W'(DEPTH);

  // Words between two pointers
  function automatic logic [PW-1:0] wordsBetween(input logic [PW-1:0] head,
                                                 input logic [PW-1:0] tail);
    wordsBetween = head - tail;
  endfunction

  logic [dcf_pkg::DATA_W-1:0] mem [DEPTH];
  logic [PW-1:0]              wrPtr_ff;
  logic [PW-1:0]              rdPtr_ff;
  logic [PW-1:0]              rdPtrSyncA_ff;
  logic [PW-1:0]              rdPtrSyncB_ff;
  logic [PW-1:0]              wrPtrSyncA_ff;
  logic [PW-1:0]              wrPtrSyncB_ff;
  logic [dcf_pkg::DATA_W-1:0] readDataOut_ff;
  logic                       outValid_ff;
  logic                       fwftMode_ff;
  logic                       serialMethod_ff;
  logic [dcf_pkg::OFS_W-1:0]  emptyOfs_ff;
  logic [dcf_pkg::OFS_W-1:0]  fullOfs_ff;
  logic                       almostFullN_ff;
  logic                       almostEmptyN_ff;
  logic [dcf_pkg::REG_DW-1:0] regRdData_ff;
  logic                       masterClr;
  logic                       anyClr;
  logic [PW-1:0]              ramCountW;
  logic [PW-1:0]              ramCountR;
  logic                       fullNow;
  logic                       ramEmptyR;
  logic                       wrAccept;
  logic                       rdLoad;
  logic                       rdDrain;
  logic                       serialShift;
  logic                       parWrite;
  logic [dcf_pkg::CNT_W-1:0]  afThresh;
  logic [dcf_pkg::CNT_W-1:0]  aeThresh;
  logic [dcf_pkg::CNT_W-1:0]  aeCount;

  // Reset qualifiers
  assign masterClr = rst | ~full_reset_n;
  assign anyClr    = masterClr | ~partial_clear_n;

  // Occupancy as seen by each side
  assign ramCountW = wordsBetween(wrPtr_ff, rdPtrSyncB_ff);
  assign ramCountR = wordsBetween(wrPtrSyncB_ff, rdPtr_ff);
  assign fullNow   = (ramCountW == DEPTH_P);
  assign ramEmptyR = (ramCountR == '0);

  // Write acceptance, blocked while full
  assign wrAccept = wrTick & ~write_en_n & ~fullNow & ~anyClr;

  // Read loading in both modes
  always_comb begin
    if (fwftMode_ff) begin
      rdLoad = rdTick & ~ramEmptyR & (~outValid_ff | ~read_en_n);
    end else begin
      rdLoad = rdTick & ~read_en_n & ~ramEmptyR;
    end
  end
  assign rdDrain = fwftMode_ff & rdTick & ~read_en_n & outValid_ff & ramEmptyR;

  // Offset programming strobes
  assign serialShift = serialMethod_ff & wrTick & ~serial_load_gate_n
                       & ~offset_access_n;
  assign parWrite    = ~serialMethod_ff & regWr & ~offset_access_n;

  // Storage array
  always_ff @(posedge clk_sys) begin
    if (wrAccept) begin
      mem[wrPtr_ff[ADDRW-1:0]] <= wrData;
    end
  end

  // Write pointer
  always_ff @(posedge clk_sys) begin
    if (anyClr) begin
      wrPtr_ff <= '0;
    end else if (wrAccept) begin
      wrPtr_ff <= wrPtr_ff + 1'b1;
    end
  end

  // Read pointer into write domain, two stages on write edges
  always_ff @(posedge clk_sys) begin
    if (anyClr) begin
      rdPtrSyncA_ff <= '0;
      rdPtrSyncB_ff <= '0;
    end else if (wrTick) begin
      rdPtrSyncA_ff <= rdPtr_ff;
      rdPtrSyncB_ff <= rdPtrSyncA_ff;
    end
  end

  // Write pointer into read domain, two stages on read edges
  always_ff @(posedge clk_sys) begin
    if (anyClr) begin
      wrPtrSyncA_ff <= '0;
      wrPtrSyncB_ff <= '0;
    end else if (rdTick) begin
      wrPtrSyncA_ff <= wrPtr_ff;
      wrPtrSyncB_ff <= wrPtrSyncA_ff;
    end
  end

  // Read pointer and output register
  always_ff @(posedge clk_sys) begin
    if (anyClr) begin
      rdPtr_ff       <= '0;
      readDataOut_ff <= '0;
    end else if (rdLoad) begin
      rdPtr_ff       <= rdPtr_ff + 1'b1;
      readDataOut_ff <= mem[rdPtr_ff[ADDRW-1:0]];
    end
  end

  // Output word valid in fall-through mode
  always_ff @(posedge clk_sys) begin
    if (anyClr) begin
      outValid_ff <= 1'b0;
    end else if (rdLoad) begin
      outValid_ff <= 1'b1;
    end else if (rdDrain) begin
      outValid_ff <= 1'b0;
    end
  end

  // Mode and method straps caught during master reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fwftMode_ff     <= 1'b0;
      serialMethod_ff <= 1'b0;
    end else if (~full_reset_n) begin
      fwftMode_ff     <= mode_or_serial_in;
      serialMethod_ff <= offset_access_n;
    end
  end

  // Offset registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      emptyOfs_ff <= dcf_pkg::OFS_DEF_PAR;
      fullOfs_ff  <= dcf_pkg::OFS_DEF_PAR;
    end else if (~full_reset_n) begin
      emptyOfs_ff <= offset_access_n ? dcf_pkg::OFS_DEF_SER : dcf_pkg::OFS_DEF_PAR;
      fullOfs_ff  <= offset_access_n ? dcf_pkg::OFS_DEF_SER : dcf_pkg::OFS_DEF_PAR;
    end else if (serialShift) begin
      {fullOfs_ff, emptyOfs_ff} <= {mode_or_serial_in, fullOfs_ff,
                                    emptyOfs_ff[dcf_pkg::OFS_W-1:1]};
    end else if (parWrite && regAddr == dcf_pkg::ADDR_EMPTY_OFS) begin
      emptyOfs_ff <= regWrData[dcf_pkg::OFS_W-1:0];
    end else if (parWrite && regAddr == dcf_pkg::ADDR_FULL_OFS) begin
      fullOfs_ff  <= regWrData[dcf_pkg::OFS_W-1:0];
    end
  end

  // Flag thresholds
  assign afThresh = DEPTH_C - dcf_pkg::CNT_W'(fullOfs_ff);
  assign aeCount  = dcf_pkg::CNT_W'(ramCountR)
                    + dcf_pkg::CNT_W'(fwftMode_ff & outValid_ff);
  assign aeThresh = dcf_pkg::CNT_W'(emptyOfs_ff)
                    + (fwftMode_ff ? dcf_pkg::FALL_THROUGH_MODE_AE_EXTRA : '0);

  // Almost-full, write edges only
  always_ff @(posedge clk_sys) begin
    if (anyClr) begin
      almostFullN_ff <= 1'b1;
    end else if (wrTick) begin
      almostFullN_ff <= ~(dcf_pkg::CNT_W'(ramCountW) >= afThresh);
    end
  end

  // Almost-empty, read edges only
  always_ff @(posedge clk_sys) begin
    if (anyClr) begin
      almostEmptyN_ff <= 1'b0;
    end else if (rdTick) begin
      almostEmptyN_ff <= ~(aeCount <= aeThresh);
    end
  end

  // Parallel read of offsets and status
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      regRdData_ff <= '0;
    end else if (regRd) begin
      case (regAddr)
        dcf_pkg::ADDR_EMPTY_OFS: regRdData_ff <= dcf_pkg::REG_DW'(emptyOfs_ff);
        dcf_pkg::ADDR_FULL_OFS:  regRdData_ff <= dcf_pkg::REG_DW'(fullOfs_ff);
        dcf_pkg::ADDR_STATUS: begin
          regRdData_ff                     <= '0;
          regRdData_ff[dcf_pkg::ST_FALL_THROUGH_MODE]   <= fwftMode_ff;
          regRdData_ff[dcf_pkg::ST_SERIAL] <= serialMethod_ff;
          regRdData_ff[dcf_pkg::ST_EMPTYN] <= emptyFlagN;
          regRdData_ff[dcf_pkg::ST_FULLN]  <= fullFlagN;
          regRdData_ff[dcf_pkg::ST_AEN]    <= almostEmptyN_ff;
          regRdData_ff[dcf_pkg::ST_AFN]    <= almostFullN_ff;
        end
        default: regRdData_ff <= '0;
      endcase
    end else begin
      regRdData_ff <= '0;
    end
  end

  // Output pins
  assign readDataOut  = readDataOut_ff;
  assign readDataOeN  = output_drive_n;
  assign fullFlagN    = fwftMode_ff ? fullNow : ~fullNow;
  assign emptyFlagN   = fwftMode_ff ? ~outValid_ff : ~ramEmptyR;
  assign almostFullN  = almostFullN_ff;
  assign almostEmptyN = almostEmptyN_ff;
  assign regRdData    = regRdData_ff;

  // Checks of the read, write and programming behaviour
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_stdLoad;
    ~fwftMode_ff & rdTick & ~read_en_n & ~ramEmptyR & ~anyClr
      |=> rdPtr_ff == $past(rdPtr_ff) + 1'b1;
  endproperty
  a_stdLoad: assert property (p_stdLoad) else $error("read word not loaded");

  property p_holdNoStrobe;
    ~fwftMode_ff & read_en_n & ~anyClr |=> $stable(readDataOut);
  endproperty
  a_holdNoStrobe: assert property (p_holdNoStrobe) else $error("data moved");

  property p_emptyIgnore;
    rdTick & ramEmptyR & ~anyClr |=> $stable(rdPtr_ff);
  endproperty
  a_emptyIgnore: assert property (p_emptyIgnore) else $error("read while empty");

  property p_emptyRise;
    ~fwftMode_ff & ~emptyFlagN & wrAccept & ~rdTick ##1 (~rdTick & ~anyClr) [*2]
      |-> ~emptyFlagN;
  endproperty
  a_emptyRise: assert property (p_emptyRise) else $error("empty rose early");

  property p_fallThrough;
    fwftMode_ff & ~outValid_ff & ~ramEmptyR & rdTick & ~anyClr
      |=> outValid_ff ##0 ~emptyFlagN;
  endproperty
  a_fallThrough: assert property (p_fallThrough) else $error("no fall-through");

  property p_lastRead;
    rdDrain & ~anyClr |=> emptyFlagN && $stable(readDataOut);
  endproperty
  a_lastRead: assert property (p_lastRead) else $error("last read wrong");

  property p_serialShift;
    serialShift & ~masterClr
      |=> fullOfs_ff[dcf_pkg::OFS_W-1] == $past(mode_or_serial_in);
  endproperty
  a_serialShift: assert property (p_serialShift) else $error("bit not shifted");

  property p_gateHold;
    serial_load_gate_n & ~regWr & ~masterClr
      |=> $stable(emptyOfs_ff) && $stable(fullOfs_ff);
  endproperty
  a_gateHold: assert property (p_gateHold) else $error("offset changed");

  property p_strap;
    ~full_reset_n & offset_access_n
      |=> serialMethod_ff && emptyOfs_ff == dcf_pkg::OFS_DEF_SER;
  endproperty
  a_strap: assert property (p_strap) else $error("serial default wrong");

  property p_fullBlock;
    fullNow & wrTick & ~rdTick & ~anyClr |=> $stable(wrPtr_ff);
  endproperty
  a_fullBlock: assert property (p_fullBlock) else $error("write when full");

  property p_partial;
    ~partial_clear_n & full_reset_n
      |=> readDataOut == '0 && $stable(fullOfs_ff) && $stable(fwftMode_ff);
  endproperty
  a_partial: assert property (p_partial) else $error("partial clear wrong");

  property p_almostFull;
    wrTick & ~anyClr & (dcf_pkg::CNT_W'(ramCountW) >= afThresh) |=> ~almostFullN;
  endproperty
  a_almostFull: assert property (p_almostFull) else $error("almost-full missing");

  property p_almostEmpty;
    rdTick & ~anyClr & (aeCount <= aeThresh) |=> ~almostEmptyN;
  endproperty
  a_almostEmpty: assert property (p_almostEmpty) else $error("almost-empty missing");

  property p_holdFwft;
    fwftMode_ff & outValid_ff & read_en_n & ~anyClr |=> $stable(readDataOut);
  endproperty
  a_holdFwft: assert property (p_holdFwft) else $error("fall-through data moved");

  property p_fwftNoEarly;
    fwftMode_ff & ~outValid_ff & ~rdTick & ~anyClr |=> ~outValid_ff;
  endproperty
  a_fwftNoEarly: assert property (p_fwftNoEarly) else $error("word fell early");

  property p_fwftIgnore;
    fwftMode_ff & emptyFlagN & ramEmptyR & ~anyClr
      |=> emptyFlagN && $stable(readDataOut);
  endproperty
  a_fwftIgnore: assert property (p_fwftIgnore) else $error("strobe not ignored");

  property p_inputSpace;
    fwftMode_ff & fullFlagN & wrTick & ~anyClr |=> $stable(wrPtr_ff);
  endproperty
  a_inputSpace: assert property (p_inputSpace) else $error("write with no space");

  property p_wrEdgeFlags;
    ~wrTick & ~anyClr |=> $stable(fullFlagN) && $stable(almostFullN);
  endproperty
  a_wrEdgeFlags: assert property (p_wrEdgeFlags) else $error("write flag moved");

  property p_rdEdgeFlags;
    ~rdTick & ~anyClr |=> $stable(emptyFlagN) && $stable(almostEmptyN);
  endproperty
  a_rdEdgeFlags: assert property (p_rdEdgeFlags) else $error("read flag moved");

  property p_methodOnly;
    serialMethod_ff & serial_load_gate_n & ~masterClr
      |=> $stable(emptyOfs_ff) && $stable(fullOfs_ff);
  endproperty
  a_methodOnly: assert property (p_methodOnly) else $error("wrong load method");

  property p_parDefault;
    ~full_reset_n & ~offset_access_n
      |=> ~serialMethod_ff && emptyOfs_ff == dcf_pkg::OFS_DEF_PAR
          && fullOfs_ff == dcf_pkg::OFS_DEF_PAR;
  endproperty
  a_parDefault: assert property (p_parDefault) else $error("parallel default wrong");

  property p_partialFlags;
    ~partial_clear_n & full_reset_n
      |=> ~almostEmptyN && almostFullN && ~outValid_ff && rdPtr_ff == '0;
  endproperty
  a_partialFlags: assert property (p_partialFlags) else $error("partial flags wrong");
endmodule

// >>> src/dcf_pkg.sv
// Constants shared by the dual-clock buffer read side and flag logic
package dcf_pkg;
  // Depth choices
  localparam int DEPTH_SMALL = 8192;
  localparam int DEPTH_LARGE = 16384;
  // Widths
  localparam int DATA_W = 18;
  localparam int OFS_W  = 14;
  localparam int CNT_W  = 16;
  localparam int REG_AW = 2;
  localparam int REG_DW = 16;
  // Default offsets chosen at master reset
  localparam logic [OFS_W-1:0] OFS_DEF_PAR = 14'h007F;
  localparam logic [OFS_W-1:0] OFS_DEF_SER = 14'h03FF;
  // Fall-through almost-empty margin
  localparam logic [CNT_W-1:0] FALL_THROUGH_MODE_AE_EXTRA = 16'h0001;
  // Register offsets
  localparam logic [REG_AW-1:0] ADDR_EMPTY_OFS = 2'h0;
  localparam logic [REG_AW-1:0] ADDR_FULL_OFS  = 2'h1;
  localparam logic [REG_AW-1:0] ADDR_STATUS    = 2'h2;
  // Status register bit positions
  localparam int ST_FALL_THROUGH_MODE   = 0;
  localparam int ST_SERIAL = 1;
  localparam int ST_EMPTYN = 2;
  localparam int ST_FULLN  = 3;
  localparam int ST_AEN    = 4;
  localparam int ST_AFN    = 5;
endpackage

// >>> sim/dcf_host_model.sv
// Far-side host clocks: write and read clock edges as tick pulses
module dcf_host_model #(
  parameter int WR_PER = 2,
  parameter int RD_PER = 3
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Host clock edges
  output logic      wrTick,
  output logic      rdTick
);
  timeunit 1ns;
  timeprecision 1ps;
  int wrCnt_ff;
  int rdCnt_ff;
  // Two unrelated edge rates; both stand still while reset is held
  always_ff @(posedge clk_sys) begin
    wrCnt_ff <= (rst || wrCnt_ff == WR_PER - 1) ? 0 : wrCnt_ff + 1;
    rdCnt_ff <= (rst || rdCnt_ff == RD_PER - 1) ? 0 : rdCnt_ff + 1;
    wrTick   <= !rst && wrCnt_ff == 0;
    rdTick   <= !rst && rdCnt_ff == RD_PER - 1;
  end
endmodule

// >>> sim/dcf_read_flags_tb_top.sv
// Self-checking bench for the dual-clock buffer read side and flags
module dcf_read_flags_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEPTH = 16;
  logic        clk_sys, rst, full_reset_n, partial_clear_n, wrTick, rdTick;
  logic        write_en_n, read_en_n, output_drive_n, readDataOeN, regWr, regRd;
  logic        offset_access_n, serial_load_gate_n, mode_or_serial_in;
  logic        fullFlagN, emptyFlagN, almostFullN, almostEmptyN;
  logic [17:0] wrData, readDataOut, lastOut, d;
  logic [1:0]  regAddr;
  logic [15:0] regWrData, regRdData;
  logic [17:0] q[$];
  logic [7:0]  seq;
  bit          fall_through_mode;
  int          miscompares, num_checks, cnt;

  // Free-running system clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  dcf_read_flags #(.DEPTH(DEPTH)) dcf_read_flags_i (
    .clk_sys(clk_sys), .rst(rst), .full_reset_n(full_reset_n),
    .partial_clear_n(partial_clear_n), .wrTick(wrTick), .write_en_n(write_en_n),
    .wrData(wrData), .rdTick(rdTick), .read_en_n(read_en_n),
    .output_drive_n(output_drive_n), .readDataOut(readDataOut), .readDataOeN(readDataOeN),
    .offset_access_n(offset_access_n), .serial_load_gate_n(serial_load_gate_n),
    .mode_or_serial_in(mode_or_serial_in), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .fullFlagN(fullFlagN),
    .emptyFlagN(emptyFlagN), .almostFullN(almostFullN), .almostEmptyN(almostEmptyN));

  dcf_host_model dcf_host_model_i (.clk_sys(clk_sys), .rst(rst), .wrTick(wrTick),
    .rdTick(rdTick));

  task automatic check(string name, logic [17:0] seen, logic [17:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic flag(string name, logic seen, logic exp);
    check(name, 18'(seen), 18'(exp));
  endtask

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Wait for n host clock edges, then let their updates land
  task automatic tick_wait(bit isRd, int n);
    repeat (n) begin
      do @(posedge clk_sys); while ((isRd ? rdTick : wrTick) !== 1'b1);
    end
    #1;
  endtask

  // One write, held until a write edge takes it; note it if space remains
  task automatic wr();
    @(posedge clk_sys);
    seq++;
    d = {1'b1, 9'($urandom), seq};
    write_en_n <= 1'b0;
    wrData     <= d;
    do @(posedge clk_sys); while (wrTick !== 1'b1);
    write_en_n <= 1'b1;
    if (cnt < DEPTH + int'(fall_through_mode)) begin
      q.push_back(d);
      cnt++;
    end
  endtask

  task automatic rd();
    @(posedge clk_sys);
    read_en_n      <= 1'b0;
    output_drive_n <= 1'($urandom);
    do @(posedge clk_sys); while (rdTick !== 1'b1);
    read_en_n <= 1'b1;
    if (cnt > 0) cnt--;
  endtask

  task automatic reg_wr(logic [1:0] a, logic [15:0] v);
    @(posedge clk_sys);
    offset_access_n <= 1'b0;
    regWr           <= 1'b1;
    regAddr         <= a;
    regWrData       <= v;
    @(posedge clk_sys);
    regWr           <= 1'b0;
    offset_access_n <= 1'b1;
  endtask

  task automatic reg_rd(logic [1:0] a, logic [15:0] exp);
    @(posedge clk_sys);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1;
    check("regRdData", 18'(regRdData), 18'(exp));
  endtask

  // Shift 28 bits, first bit ends in empty offset bit 0; then gate high
  task automatic ser_load(logic [27:0] bits);
    @(posedge clk_sys);
    offset_access_n    <= 1'b0;
    serial_load_gate_n <= 1'b0;
    for (int i = 0; i < 28; i++) begin
      mode_or_serial_in <= bits[i];
      do @(posedge clk_sys); while (wrTick !== 1'b1);
    end
    serial_load_gate_n <= 1'b1;
    mode_or_serial_in  <= 1'($urandom);
    tick_wait(1'b0, 3);
    offset_access_n <= 1'b1;
  endtask

  task automatic after_rst();
    q.delete();
    cnt = 0;
    @(posedge clk_sys);
    #1;
    flag("emptyFlagN", emptyFlagN, fall_through_mode);
    flag("fullFlagN", fullFlagN, !fall_through_mode);
    flag("almostEmptyN", almostEmptyN, 1'b0);
    flag("almostFullN", almostFullN, 1'b1);
  endtask

  task automatic full_rst(bit mode, bit acc);
    @(posedge clk_sys);
    full_reset_n      <= 1'b0;
    mode_or_serial_in <= mode;
    offset_access_n   <= acc;
    repeat (2) @(posedge clk_sys);
    full_reset_n      <= 1'b1;
    offset_access_n   <= 1'b1;
    mode_or_serial_in <= 1'b0;
    fall_through_mode = mode;
    after_rst();
  endtask

  // Each new word on the outputs must be the oldest noted word
  always @(posedge clk_sys) begin
    if (!rst && readDataOut !== lastOut && readDataOut !== 18'h0_0000) begin
      if (q.size() == 0)
        check("unexpected load", readDataOut, lastOut);
      else
        check("readDataOut", readDataOut, q.pop_front());
    end
    lastOut <= readDataOut;
  end

  // Pin enable follows the drive input
  always @(negedge clk_sys) flag("readDataOeN", readDataOeN, output_drive_n);

  // Hang guard
  initial begin
    #400000;
    miscompares++;
    final_report();
  end

  initial begin
    {rst, full_reset_n, partial_clear_n, write_en_n, read_en_n} = 5'h1f;
    {output_drive_n, offset_access_n, serial_load_gate_n} = 3'h3;
    {mode_or_serial_in, regWr, regRd, fall_through_mode} = 4'h0;
    {wrData, lastOut, d, regAddr, regWrData, seq} = '0;
    void'($urandom(18109));
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    // Standard mode, parallel offsets
    full_rst(1'b0, 1'b0);
    reg_rd(2'h0, 16'h007f);
    reg_rd(2'h1, 16'h007f);
    reg_rd(2'h3, 16'h0000);
    reg_wr(2'h0, 16'h0003);
    reg_wr(2'h1, 16'h0004);
    reg_rd(2'h0, 16'h0003);
    reg_rd(2'h1, 16'h0004);
    rd();
    wr();
    tick_wait(1'b1, 1);
    flag("emptyFlagN", emptyFlagN, 1'b0);
    tick_wait(1'b1, 1);
    flag("emptyFlagN", emptyFlagN, 1'b1);
    rd();
    tick_wait(1'b1, 4);
    flag("emptyFlagN", emptyFlagN, 1'b0);
    for (int i = 0; i < DEPTH + 1; i++) begin
      wr();
      if (i == 10 || i == 11) begin
        tick_wait(1'b0, 2);
        flag("almostFullN", almostFullN, i == 10);
      end
    end
    tick_wait(1'b0, 2);
    flag("fullFlagN", fullFlagN, 1'b0);
    tick_wait(1'b1, 3);
    flag("almostEmptyN", almostEmptyN, 1'b1);
    repeat (DEPTH) rd();
    tick_wait(1'b1, 3);
    flag("almostEmptyN", almostEmptyN, 1'b0);
    flag("emptyFlagN", emptyFlagN, 1'b0);
    // Fall-through mode, serial offsets
    full_rst(1'b1, 1'b1);
    reg_rd(2'h0, 16'h03ff);
    reg_rd(2'h2, 16'h0027);
    ser_load({14'h0003, 14'h0002});
    reg_wr(2'h0, 16'h0005);
    reg_rd(2'h0, 16'h0002);
    reg_rd(2'h1, 16'h0003);
    wr();
    tick_wait(1'b1, 2);
    check("readDataOut", readDataOut, 18'h0_0000);
    flag("emptyFlagN", emptyFlagN, 1'b1);
    tick_wait(1'b1, 1);
    check("readDataOut", readDataOut, d);
    flag("emptyFlagN", emptyFlagN, 1'b0);
    rd();
    #1;
    flag("emptyFlagN", emptyFlagN, 1'b1);
    check("readDataOut", readDataOut, d);
    rd();
    for (int i = 0; i < DEPTH + 2; i++) wr();
    tick_wait(1'b0, 3);
    flag("fullFlagN", fullFlagN, 1'b1);
    flag("almostFullN", almostFullN, 1'b0);
    for (int i = 0; i < DEPTH + 1; i++) begin
      rd();
      if (i == 12 || i == 13) begin
        tick_wait(1'b1, 3);
        flag("almostEmptyN", almostEmptyN, i == 12);
      end
    end
    // Partial reset keeps offsets and mode
    wr();
    wr();
    tick_wait(1'b1, 4);
    @(posedge clk_sys);
    partial_clear_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    partial_clear_n <= 1'b1;
    after_rst();
    check("readDataOut", readDataOut, 18'h0_0000);
    reg_rd(2'h0, 16'h0002);
    reg_rd(2'h2, 16'h0027);
    final_report();
  end
endmodule
